// ==== rtl/bootstrap_strap_config.sv ====
// Reset-time strap capture and configuration decode
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module bootstrap_strap_config
  import strap_cfg_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              dbg_en_strap,
  input  wire logic              brk_in,
  input  wire logic              mem_ifsel_strap,
  input  wire logic              mem_iffreq_strap,
  input  wire logic              mem_ifwidth_strap,
  input  wire logic              mem_clksel_strap,
  input  wire logic [GPIO_W-1:0] gpio_in,
  output logic                   dbg_bus_clk_en,
  output logic [ELINK_CNT-1:0]   ethernet_debug_link_en,
  output logic [ELINK_CNT-1:0]   ethernet_debug_link_route_dbg,
  output logic [NIB_W-1:0]       ethernet_debug_link0_addr_nib,
  output logic [NIB_W-1:0]       ethernet_debug_link1_addr_nib,
  output logic [CPU_CNT-1:0]     cpu_debug_force,
  output logic                   wdog_enable,
  output logic                   cpu0_start,
  output logic                   mem_sel_sdr,
  output logic [6:0]             mem_data_bits,
  output logic [5:0]             mem_check_bits,
  output logic                   mem_clk_alt_src,
  output logic [1:0]             mem_clk_ratio_sel,
  output logic [4:0]             prom_width_bits,
  output logic                   prom_present,
  output logic                   router_clk_en,
  output logic [RID_W-1:0]       router_id_low,
  output logic                   rom_check_enable,
  output logic                   usb_test_mode,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  strap_snap_if snap ();

  strap_snap_store u_store (
    .aclk    (aclk),
    .aresetn (aresetn),
    .snap    (snap)
  );

  load_state_t       state_r;
  load_state_t       state_nxt;
  logic              reload_req_r;
  logic              rom_chk_sw_r;
  logic              rom_chk_ovr_r;
  logic [SNAP_W-1:0] sv;

  // Live strap word, captured while reset is held or on reload
  wire [SNAP_W-1:0] live_word = {mem_clksel_strap, mem_ifwidth_strap,
                                 mem_iffreq_strap, mem_ifsel_strap,
                                 brk_in, dbg_en_strap, gpio_in};
  wire in_reset = !aresetn;

  assign snap.wr_en   = in_reset || (state_r == ST_RELOAD);
  assign snap.wr_data = live_word;
  assign sv           = snap.rd_data;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_CAPTURE: state_nxt = ST_HOLD;
      ST_HOLD:    if (reload_req_r) state_nxt = ST_RELOAD;
      ST_RELOAD:  state_nxt = ST_HOLD;
      default:    state_nxt = ST_HOLD;
    endcase
  end

  // Decoded configuration from the held snapshot; break force from live brk_in, ROM check overridable by software
  wire dbg     = sv[SN_DBG_EN];
  wire brk     = sv[SN_BRK];
  wire ifsel   = sv[SN_IFSEL];
  wire [GPIO_W-1:0] g = sv[SN_GPIO_LSB +: GPIO_W];

  wire              d_dbg_clk  = dbg;
  logic [ELINK_CNT-1:0] d_el_en;
  logic [CPU_CNT-1:0]   d_dbgf;
  wire              d_wdog     = !dbg && brk;
  wire              d_start    = dbg ? 1'b1 : brk;
  wire              d_sdr      = ifsel;
  wire [6:0] d_dbits = sv[SN_IFWIDTH] ? DATA_W_NARROW : DATA_W_WIDE;
  wire [5:0] d_cbits = sv[SN_IFWIDTH] ? CHK_W_NARROW : CHK_W_WIDE;
  wire              d_alt      = sv[SN_CLKSEL];
  wire [1:0]        d_ratio    = {ifsel, sv[SN_IFFREQ]};
  wire [NIB_W-1:0]  d_nib0     = g[NIB0_LSB +: NIB_W];
  wire [NIB_W-1:0]  d_nib1     = g[NIB1_LSB +: NIB_W];
  wire [ELINK_CNT-1:0] d_route = {g[ROUTE1_BIT], g[ROUTE0_BIT]};
  wire [4:0] d_pw = g[PROM_W_BIT] ? PROM_W_16 : PROM_W_8;
  wire              d_pres     = g[PROM_PRES_BIT];
  wire [RID_W-1:0]  d_rid      = g[RID_LSB +: RID_W];
  wire              d_rchk     = rom_chk_ovr_r ? rom_chk_sw_r
                                               : g[ROM_CHK_BIT];
  wire              d_usbt     = g[USB_TEST_BIT];

  // One enable per debug link, one break force per processor
  for (genvar i = 0; i < ELINK_CNT; i++) begin : g_link
    assign d_el_en[i] = dbg;
  end
  for (genvar i = 0; i < CPU_CNT; i++) begin : g_cpu
    assign d_dbgf[i] = dbg && brk_in;
  end

  // AXI4-Lite slave, one outstanding write and read
  logic aw_have_r;
  logic w_have_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire do_wr   = aw_have_r && w_have_r && !s_axi_bvalid;
  wire wr_ctrl = (aw_addr_r >> DEC_SHIFT) == (ADDR_CTRL >> DEC_SHIFT);
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [9:0] rd_idx = s_axi_araddr[11:2];
  wire rd_snap  = rd_idx == ADDR_SNAP[11:2];
  wire rd_stat  = rd_idx == ADDR_STATUS[11:2];
  wire rd_ctrl  = rd_idx == ADDR_CTRL[11:2];
  wire rd_hit   = rd_snap || rd_stat || rd_ctrl;
  wire [31:0] status_word = {24'h000000, state_r == ST_HOLD,
                             d_rchk, d_usbt, d_pres,
                             d_wdog, d_start, d_sdr, d_dbg_clk};
  wire [31:0] ctrl_word = {29'h00000000, reload_req_r,
                           rom_chk_ovr_r, rom_chk_sw_r};
  wire [31:0] rd_word = rd_snap ? {10'h000, sv} :
                        rd_stat ? status_word :
                        rd_ctrl ? ctrl_word : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 12'h000;
    end else if (do_wr) begin
      aw_have_r <= 1'b0;
    end else if (aw_take) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end else if (do_wr) begin
      w_have_r <= 1'b0;
    end else if (w_take) begin
      w_have_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
  end

  // Response once both halves of a write are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ctrl ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_r && !aw_take && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_r && !w_take && !s_axi_bvalid;
    end
  end

  wire ctrl_wr = do_wr && wr_ctrl && w_strb_r[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rom_chk_sw_r  <= 1'b0;
      rom_chk_ovr_r <= 1'b0;
    end else if (ctrl_wr) begin
      rom_chk_sw_r  <= w_data_r[0];
      rom_chk_ovr_r <= w_data_r[1];
    end
  end

  // Reload request clears itself once the new snapshot is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_req_r <= 1'b0;
    end else if (ctrl_wr) begin
      reload_req_r <= w_data_r[2];
    end else if (state_r == ST_RELOAD) begin
      reload_req_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_CAPTURE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Registered configuration outputs; held at reset defaults while in reset (wide memory, 8-bit PROM, rest low)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbg_bus_clk_en                <= 1'b0;
      ethernet_debug_link_en        <= '0;
      ethernet_debug_link_route_dbg <= '0;
      ethernet_debug_link0_addr_nib <= '0;
      ethernet_debug_link1_addr_nib <= '0;
    end else begin
      dbg_bus_clk_en                <= d_dbg_clk;
      ethernet_debug_link_en        <= d_el_en;
      ethernet_debug_link_route_dbg <= d_route;
      ethernet_debug_link0_addr_nib <= d_nib0;
      ethernet_debug_link1_addr_nib <= d_nib1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_debug_force <= '0;
      wdog_enable     <= 1'b0;
      cpu0_start      <= 1'b0;
    end else begin
      cpu_debug_force <= d_dbgf;
      wdog_enable     <= d_wdog;
      cpu0_start      <= d_start;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_sel_sdr       <= 1'b0;
      mem_data_bits     <= DATA_W_WIDE;
      mem_check_bits    <= CHK_W_WIDE;
      mem_clk_alt_src   <= 1'b0;
      mem_clk_ratio_sel <= 2'h0;
    end else begin
      mem_sel_sdr       <= d_sdr;
      mem_data_bits     <= d_dbits;
      mem_check_bits    <= d_cbits;
      mem_clk_alt_src   <= d_alt;
      mem_clk_ratio_sel <= d_ratio;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prom_width_bits <= PROM_W_8;
      prom_present    <= 1'b0;
      router_clk_en   <= 1'b0;
      router_id_low   <= '0;
    end else begin
      prom_width_bits <= d_pw;
      prom_present    <= d_pres;
      router_clk_en   <= d_pres;
      router_id_low   <= d_rid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rom_check_enable <= 1'b0;
      usb_test_mode    <= 1'b0;
    end else begin
      rom_check_enable <= d_rchk;
      usb_test_mode    <= d_usbt;
    end
  end
endmodule : bootstrap_strap_config

// ==== rtl/strap_cfg_pkg.sv ====
// Constants for the reset-time configuration loader
package strap_cfg_pkg;
  localparam int GPIO_W          = 16;
  localparam int NIB0_LSB        = 0;
  localparam int NIB1_LSB        = 4;
  localparam int NIB_W           = 4;
  localparam int ROUTE0_BIT      = 8;
  localparam int ROUTE1_BIT      = 9;
  localparam int PROM_W_BIT      = 10;
  localparam int PROM_PRES_BIT   = 11;
  localparam int RID_LSB         = 12;
  localparam int RID_W           = 2;
  localparam int ROM_CHK_BIT     = 14;
  localparam int USB_TEST_BIT    = 15;
  localparam int CPU_CNT         = 4;
  localparam int ELINK_CNT       = 2;
  localparam int SNAP_W          = 22;
  // Snapshot word layout
  localparam int SN_GPIO_LSB     = 0;
  localparam int SN_DBG_EN       = 16;
  localparam int SN_BRK          = 17;
  localparam int SN_IFSEL        = 18;
  localparam int SN_IFFREQ       = 19;
  localparam int SN_IFWIDTH      = 20;
  localparam int SN_CLKSEL       = 21;
  // AXI4-Lite register map (byte addresses)
  localparam logic [11:0] ADDR_SNAP   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CTRL   = 12'h008;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [1:0]  DEC_SHIFT   = 2'h2;
  // Memory width codes
  localparam logic [6:0]  DATA_W_WIDE   = 7'h40;
  localparam logic [6:0]  DATA_W_NARROW = 7'h20;
  localparam logic [5:0]  CHK_W_WIDE    = 6'h20;
  localparam logic [5:0]  CHK_W_NARROW  = 6'h10;
  localparam logic [4:0]  PROM_W_8      = 5'h08;
  localparam logic [4:0]  PROM_W_16     = 5'h10;
  typedef enum logic [2:0] {
    ST_CAPTURE = 3'b001,
    ST_HOLD    = 3'b010,
    ST_RELOAD  = 3'b100
  } load_state_t;
endpackage : strap_cfg_pkg

// ==== rtl/strap_snap_if.sv ====
// Carrier between loader and its snapshot store
`timescale 1ns/1ps
interface strap_snap_if;
  import strap_cfg_pkg::*;
  logic              wr_en;
  logic [SNAP_W-1:0] wr_data;
  logic [SNAP_W-1:0] rd_data;
  modport owner (output wr_en, output wr_data, input rd_data);
  modport store (input wr_en, input wr_data, output rd_data);
endinterface : strap_snap_if

// ==== rtl/strap_snap_store.sv ====
// Registered store of the strap snapshot
`timescale 1ns/1ps
module strap_snap_store
  import strap_cfg_pkg::*;
(
  input  wire logic    aclk,
  input  wire logic    aresetn,
  strap_snap_if.store  snap
);
  logic [SNAP_W-1:0] snap_r;

  // Loads, not clears, while reset is low
  always_ff @(posedge aclk) begin
    if (!aresetn || snap.wr_en) begin
      snap_r <= snap.wr_data;
    end
  end

  assign snap.rd_data = snap_r;
endmodule : strap_snap_store

// ==== verif/strap_board.sv ====
// Board strap wiring seen by the loader
`timescale 1ns/1ps
module strap_board
  import strap_cfg_pkg::*;
(
  input  wire logic [SNAP_W-1:0] pat,
  output logic                   mem_clksel_strap,
  output logic                   mem_ifwidth_strap,
  output logic                   mem_iffreq_strap,
  output logic                   mem_ifsel_strap,
  output logic                   brk_in,
  output logic                   dbg_en_strap,
  output logic [GPIO_W-1:0]      gpio_in,
  output logic [15:0]            prom_data
);
  // Pin 15 is low unless the USB link test mode is wanted
  assign {mem_clksel_strap, mem_ifwidth_strap, mem_iffreq_strap,
          mem_ifsel_strap, brk_in, dbg_en_strap, gpio_in} = pat;
  // Without PROM the data bus is pulled low
  assign prom_data = gpio_in[PROM_PRES_BIT] ? 16'h5a3c : 16'h0000;
endmodule : strap_board

// ==== verif/strap_cfg_checker.sv ====
// Assertion checker for the strap configuration loader
`timescale 1ns/1ps
module strap_cfg_checker
  import strap_cfg_pkg::*;
(
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 brk_in,
  input wire logic                 dbg_bus_clk_en,
  input wire logic                 wdog_enable,
  input wire logic                 cpu0_start,
  input wire logic                 mem_sel_sdr,
  input wire logic                 prom_present,
  input wire logic                 router_clk_en,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic [ELINK_CNT-1:0] ethernet_debug_link_en,
  input wire logic [1:0]           mem_clk_ratio_sel,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic [CPU_CNT-1:0]   cpu_debug_force,
  input wire logic [6:0]           mem_data_bits,
  input wire logic [5:0]           mem_check_bits,
  input wire logic [4:0]           prom_width_bits
);
  logic [3:0]  wr_age_r;
  logic [20:0] cfg_w;
  assign cfg_w = {dbg_bus_clk_en, ethernet_debug_link_en, wdog_enable,
                  cpu0_start, mem_sel_sdr, mem_data_bits, mem_clk_ratio_sel,
                  prom_width_bits, prom_present};
  // Cycles since a write address was last taken
  always_ff @(posedge aclk)
    if (!aresetn) wr_age_r <= 4'hf;
    else if (s_axi_awvalid && s_axi_awready) wr_age_r <= 4'h0;
    else if (wr_age_r != 4'hf) wr_age_r <= wr_age_r + 4'h1;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_link_en; ethernet_debug_link_en == {2{dbg_bus_clk_en}}; endproperty
  property p_chk_bits;
    (mem_data_bits == DATA_W_WIDE && mem_check_bits == CHK_W_WIDE) ||
    (mem_data_bits == DATA_W_NARROW && mem_check_bits == CHK_W_NARROW);
  endproperty
  property p_prom_rtr; prom_present == router_clk_en; endproperty
  property p_wdog;
    dbg_bus_clk_en ? (cpu0_start && !wdog_enable) : (cpu0_start == wdog_enable);
  endproperty
  property p_force;
    $past(aresetn) && $stable(dbg_bus_clk_en) |->
      cpu_debug_force == {CPU_CNT{dbg_bus_clk_en & $past(brk_in)}};
  endproperty
  property p_ratio; mem_clk_ratio_sel[1] == mem_sel_sdr; endproperty
  property p_promw;
    prom_width_bits == PROM_W_8 || prom_width_bits == PROM_W_16;
  endproperty
  property p_hold;
    $past(aresetn, 2) && $past(aresetn) && $changed(cfg_w) |-> wr_age_r < 4'h8;
  endproperty
  property p_rst;
    disable iff (1'b0) !aresetn ##1 !aresetn |-> mem_data_bits == DATA_W_WIDE
      && !dbg_bus_clk_en && !s_axi_bvalid && !s_axi_arready;
  endproperty
  property p_wlat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_link_en: assert property (p_link_en) else $error("link enable");
  a_chk_bits: assert property (p_chk_bits) else $error("mem width");
  a_prom_rtr: assert property (p_prom_rtr) else $error("router gate");
  a_wdog: assert property (p_wdog) else $error("watchdog start");
  a_force: assert property (p_force) else $error("debug force");
  a_ratio: assert property (p_ratio) else $error("clock ratio");
  a_promw: assert property (p_promw) else $error("prom width");
  a_hold: assert property (p_hold) else $error("config moved");
  a_rst: assert property (p_rst) else $error("reset values");
  a_wlat: assert property (p_wlat) else $error("write response");
  a_rlat: assert property (p_rlat) else $error("read response");
  c_dbg: cover property (dbg_bus_clk_en && cpu_debug_force == 4'hf);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_wdog: cover property (wdog_enable);
endmodule : strap_cfg_checker
bind bootstrap_strap_config strap_cfg_checker u_chk (.*);

// ==== verif/testbench.sv ====
// Self-checking bench for the strap configuration loader
`timescale 1ns/1ps
module testbench;
  import strap_cfg_pkg::*;
  logic aclk, aresetn, dbg_en_strap, brk_in, mem_ifsel_strap, mem_iffreq_strap;
  logic mem_ifwidth_strap, mem_clksel_strap, dbg_bus_clk_en, wdog_enable;
  logic cpu0_start, mem_sel_sdr, mem_clk_alt_src, prom_present, router_clk_en;
  logic rom_check_enable, usb_test_mode;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] ethernet_debug_link_en, ethernet_debug_link_route_dbg;
  logic [1:0] mem_clk_ratio_sel, router_id_low, s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0] ethernet_debug_link0_addr_nib, ethernet_debug_link1_addr_nib;
  logic [3:0] cpu_debug_force, s_axi_wstrb;
  logic [6:0] mem_data_bits;
  logic [5:0] mem_check_bits;
  logic [4:0] prom_width_bits;
  logic [15:0] prom_data;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [GPIO_W-1:0] gpio_in;
  logic [SNAP_W-1:0] pat, p;
  logic [46:0] cfg_now;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  bootstrap_strap_config uut (.*);
  strap_board brd (.pat(pat), .prom_data(prom_data), .*);
  assign cfg_now = {dbg_bus_clk_en, ethernet_debug_link_en,
    ethernet_debug_link_route_dbg, ethernet_debug_link0_addr_nib,
    ethernet_debug_link1_addr_nib, cpu_debug_force, wdog_enable, cpu0_start,
    mem_sel_sdr, mem_data_bits, mem_check_bits, mem_clk_alt_src,
    mem_clk_ratio_sel, prom_width_bits, prom_present, router_clk_en,
    router_id_low, rom_check_enable, usb_test_mode};
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  function automatic logic [46:0] exp_cfg(input logic [SNAP_W-1:0] s,
      input logic b, input logic [1:0] o);
    logic d;
    d = s[SN_DBG_EN];
    return {d, {2{d}}, s[9:8], s[3:0], s[7:4], {4{d & b}}, !d & s[SN_BRK],
      d | s[SN_BRK], s[SN_IFSEL], s[SN_IFWIDTH] ? DATA_W_NARROW : DATA_W_WIDE,
      s[SN_IFWIDTH] ? CHK_W_NARROW : CHK_W_WIDE, s[SN_CLKSEL], s[SN_IFSEL],
      s[SN_IFFREQ], s[10] ? PROM_W_16 : PROM_W_8, s[11], s[11], s[13:12],
      o[1] ? o[0] : s[14], s[15]};
  endfunction : exp_cfg
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic reset_with(input logic [SNAP_W-1:0] v);
    aresetn <= 1'b0;
    pat <= v;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask : reset_with
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
      output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
      output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  initial begin
    aresetn = 1'b0;
    pat = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    s_axi_rready = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    void'($urandom(89));
    @(posedge aclk);
    for (int i = 0; i < 12; i++) begin
      p = (i == 0) ? '0 : (i == 1) ? '1 : SNAP_W'($urandom());
      reset_with(p);
      chk(cfg_now, exp_cfg(p, p[SN_BRK], 2'b00));
      chk(cfg_now[46:40], {p[SN_DBG_EN], {2{p[SN_DBG_EN]}}, p[9:8], p[3:2]});
      chk(prom_data == 16'h0000, !prom_present);
      axi_rd(ADDR_SNAP, rd, rsp);
      chk({rsp, rd}, {RESP_OKAY, 10'h0, p});
      pat <= ~p;
      repeat (3) @(posedge aclk);
      chk(cfg_now, exp_cfg(p, ~p[SN_BRK], 2'b00));
    end
    $display("test strap_capture done");
    axi_wr(ADDR_CTRL, {30'h0, 1'b1, ~p[ROM_CHK_BIT]}, rsp);
    chk(rsp, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(cfg_now, exp_cfg(p, ~p[SN_BRK], {1'b1, ~p[ROM_CHK_BIT]}));
    axi_rd(ADDR_CTRL, rd, rsp);
    chk({rsp, rd}, {RESP_OKAY, 30'h0, 1'b1, ~p[ROM_CHK_BIT]});
    axi_rd(ADDR_STATUS, rd, rsp);
    chk({rsp, rd}, {RESP_OKAY, 24'h0, 1'b1, ~p[ROM_CHK_BIT], p[USB_TEST_BIT],
        p[PROM_PRES_BIT], !p[SN_DBG_EN] & p[SN_BRK], p[SN_DBG_EN] | p[SN_BRK],
        p[SN_IFSEL], p[SN_DBG_EN]});
    axi_wr(ADDR_SNAP, 32'hffff_ffff, rsp);
    chk(rsp, RESP_SLVERR);
    axi_rd(12'h010, rd, rsp);
    chk({rsp, rd}, {RESP_SLVERR, 32'h0});
    chk(cfg_now, exp_cfg(p, ~p[SN_BRK], {1'b1, ~p[ROM_CHK_BIT]}));
    $display("test registers done");
    axi_wr(ADDR_CTRL, 32'h0000_0004, rsp);
    repeat (3) @(posedge aclk);
    chk(cfg_now, exp_cfg(~p, ~p[SN_BRK], 2'b00));
    $display("test reload done");
    finish_test();
  end
endmodule : testbench
